// [light_load_burst_mode_sequencer.sv]
// Purpose: Light-load burst sequencer: mode selection, packets, wake line.
// Assumes: Comparator inputs are asynchronous; other inputs are synchronous.
// Notes: In adaptive mode packets are run elsewhere; this block only measures.
// Functional notes
// R1: Two-pulse adaptive burst, rate below 25 kHz twice in a row: low-power, no high side.
// R2: Low-power mode keeps two pulses per packet at a fixed 25 kHz rate.
// R3: Low-power mode regulates via peak threshold from the loop, not packet timing.
// R4: Each packet raises wake first, waits wake delay, then first low-side pulse.
// R5: Without high side, each low-side pulse starts on a zero-crossing valley.
// R6: Zero crossing after the last pulse drops wake and waits for next packet.
// R7: Strap to reference in low-power mode selects voltage-mode on-time control.
// R8: Threshold at floor moves low-power to first standby, high side stays off.
// R9: First standby: two pulses, floor threshold, only off-time regulates.
// R10: First standby goes to second standby when rate falls below 8.5 kHz.
// R11: Second standby doubles the pulses per packet of first standby.
// R12: Second standby takes program-pin threshold clamped to 0.27 V..0.4 V.
// R13: Program pin low: floor threshold, return above 8.5 kHz.
// R14: Program pin high: return to first standby only above 1.7 kHz.
// R15: Wake line stays high at least 2.2 us before the first pulse.
// R16: Packet rate is measured as clock cycles between packet starts.
// R17: Comparator inputs are synchronised before use.
`timescale 1ns/1ps
module light_load_burst_mode_sequencer
  import lbm_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOWPWR_CYC = CNT_W'(LOWPWR_PERIOD_CYC),
  parameter logic [CNT_W-1:0] ENTRY_CYC = CNT_W'(ENTRY_PERIOD_CYC),
  parameter logic [CNT_W-1:0] RETURN_CYC = CNT_W'(RETURN_PERIOD_CYC),
  parameter logic [THR_W-1:0] FLOOR_MV = THR_MIN_MV
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Adaptive burst status and packet demands
  input wire logic abmTwoPulses,
  input wire logic abmPacketStart,
  input wire logic packetDemand,
  input wire logic optionStrapRef,
  // Asynchronous comparators
  input wire logic auxZeroCrossing,
  input wire logic thresholdFloor,
  input wire logic peakProgramPinHigh,
  // Threshold sources
  input wire logic [THR_W-1:0] loopThresholdMv,
  input wire logic [THR_W-1:0] programThresholdMv,
  // Gate driver side
  output logic wakeLine,
  output logic lowSideGatePulse,
  output logic highSideEnable,
  output logic voltageMode,
  // Status
  output mode_t burstMode,
  output logic [PPP_W-1:0] pulsesPerPacket,
  output logic [THR_W-1:0] peakThresholdMv,
  output src_t thrSource
);

  // ==========================================================
  // Helpers
  function automatic logic [PPP_W-1:0] pppOf(input mode_t m);
    case (m)
      ST_LOWPOWER: pppOf = PPP_LOW; // [R2]
      ST_FIRST_STANDBY: pppOf = PPP_LOW; // [R9]
      ST_SECOND_STANDBY: pppOf = PPP_SECOND; // [R11]
      default: pppOf = PPP_RESET;
    endcase
  endfunction : pppOf

  function automatic logic [THR_W-1:0] clampThr(input logic [THR_W-1:0] v);
    if (v < THR_MIN_MV) begin
      clampThr = THR_MIN_MV;
    end else if (v > THR_MAX_MV) begin
      clampThr = THR_MAX_MV;
    end else begin
      clampThr = v;
    end
  endfunction : clampThr

  // ==========================================================
  // Synchronisers
  // Bit 0 zero crossing, bit 1 threshold floor, bit 2 program pin high.
  logic [2:0] asyncIn;
  logic [2:0] syncMeta;
  logic [2:0] syncOut;

  assign asyncIn = {peakProgramPinHigh, thresholdFloor, auxZeroCrossing};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        syncMeta[i] <= 1'b0;
        syncOut[i] <= 1'b0;
      end else begin
        syncMeta[i] <= asyncIn[i]; // [R17]
        syncOut[i] <= syncMeta[i]; // [R17]
      end
    end
  end

  logic zcdPrev;
  logic zcdEdge;
  logic floorS;
  logic progHighS;

  assign zcdEdge = syncOut[0] & ~zcdPrev;
  assign floorS = syncOut[1];
  assign progHighS = syncOut[2];

  // ==========================================================
  // Sequencer state
  mode_t mode;
  pkt_t pkt;
  logic [CNT_W-1:0] periodCnt;
  logic [WCNT_W-1:0] waitCnt;
  logic [PPP_W-1:0] pulseCnt;
  logic [1:0] slowCnt;

  mode_t next_mode;
  pkt_t next_pkt;
  logic [CNT_W-1:0] next_periodCnt;
  logic [WCNT_W-1:0] next_waitCnt;
  logic [PPP_W-1:0] next_pulseCnt;
  logic [1:0] next_slowCnt;
  logic next_wakeLine;
  logic next_lowSideGatePulse;
  logic next_highSideEnable;
  logic next_voltageMode;
  logic [PPP_W-1:0] next_pulsesPerPacket;
  logic [THR_W-1:0] next_peakThresholdMv;
  src_t next_thrSource;
  logic startReq;
  logic pktStart;

  always_comb begin
    next_mode = mode;
    next_pkt = pkt;
    next_waitCnt = waitCnt;
    next_pulseCnt = pulseCnt;
    next_slowCnt = slowCnt;
    next_wakeLine = wakeLine;
    next_lowSideGatePulse = 1'b0;
    next_periodCnt = (periodCnt == '1) ? periodCnt : periodCnt + 18'h00001;

    // In low-power mode packets follow a fixed timer, not the loop.
    case (mode)
      ST_ADAPTIVE: startReq = abmPacketStart;
      ST_LOWPOWER: startReq = (periodCnt >= LOWPWR_CYC - 18'h00001); // [R2] [R3]
      ST_FIRST_STANDBY: startReq = packetDemand; // [R9]
      ST_SECOND_STANDBY: startReq = packetDemand;
      default: startReq = 1'b0;
    endcase
    pktStart = startReq && (mode == ST_ADAPTIVE || pkt == PK_IDLE);

    // Mode decisions at a packet start use the period that just ended.
    if (pktStart) begin
      next_periodCnt = '0; // [R16]
      case (mode)
        ST_ADAPTIVE: begin
          if (abmTwoPulses && periodCnt > LOWPWR_CYC) begin
            next_slowCnt = slowCnt + 2'h1;
            if (slowCnt + 2'h1 >= SLOW_QUAL) begin
              next_mode = ST_LOWPOWER; // [R1]
              next_slowCnt = 2'h0;
            end
          end else begin
            next_slowCnt = 2'h0; // [R1]
          end
        end
        ST_FIRST_STANDBY: begin
          if (periodCnt > ENTRY_CYC) begin
            next_mode = ST_SECOND_STANDBY; // [R10]
          end
        end
        ST_SECOND_STANDBY: begin
          if (progHighS) begin
            if (periodCnt < RETURN_CYC) begin
              next_mode = ST_FIRST_STANDBY; // [R14]
            end
          end else if (periodCnt < ENTRY_CYC) begin
            next_mode = ST_FIRST_STANDBY; // [R13]
          end
        end
        default: next_mode = mode;
      endcase
    end
    if (mode == ST_LOWPOWER && floorS) begin
      next_mode = ST_FIRST_STANDBY; // [R8]
    end

    // Packet: wake, wake delay, then one pulse per valley.
    case (pkt)
      PK_IDLE: begin
        if (pktStart && mode != ST_ADAPTIVE) begin
          next_wakeLine = 1'b1; // [R4]
          next_waitCnt = '0;
          next_pulseCnt = '0;
          next_pkt = PK_WAKE;
        end
      end
      PK_WAKE: begin
        next_waitCnt = waitCnt + 10'h001;
        if (waitCnt >= WAKE_LAST) begin
          next_pkt = PK_VALLEY; // [R4] [R15]
        end
      end
      PK_VALLEY: begin
        if (zcdEdge) begin
          if (pulseCnt >= pppOf(mode)) begin
            next_wakeLine = 1'b0; // [R6]
            next_pkt = PK_IDLE;
          end else begin
            next_lowSideGatePulse = 1'b1; // [R5]
            next_pulseCnt = pulseCnt + 4'h1;
          end
        end
      end
      default: begin
        next_pkt = PK_IDLE;
        next_wakeLine = 1'b0;
      end
    endcase
    next_highSideEnable = (next_mode == ST_ADAPTIVE); // [R1] [R8]
    next_voltageMode = (next_mode == ST_LOWPOWER) && optionStrapRef; // [R7]
    next_pulsesPerPacket = pppOf(next_mode);
    // Threshold source per mode.
    case (next_mode)
      ST_LOWPOWER: begin
        next_peakThresholdMv = loopThresholdMv; // [R3]
        next_thrSource = SRC_LOOP;
      end
      ST_FIRST_STANDBY: begin
        next_peakThresholdMv = FLOOR_MV; // [R9]
        next_thrSource = SRC_FLOOR;
      end
      ST_SECOND_STANDBY: begin
        if (progHighS) begin
          next_peakThresholdMv = clampThr(programThresholdMv); // [R12]
          next_thrSource = SRC_PROGRAM;
        end else begin
          next_peakThresholdMv = THR_MIN_MV; // [R13]
          next_thrSource = SRC_FLOOR;
        end
      end
      default: begin
        next_peakThresholdMv = loopThresholdMv;
        next_thrSource = SRC_LOOP;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode <= ST_ADAPTIVE;
      pkt <= PK_IDLE;
      periodCnt <= '0;
      waitCnt <= '0;
      pulseCnt <= '0;
      slowCnt <= 2'h0;
      zcdPrev <= 1'b0;
      wakeLine <= 1'b0;
      lowSideGatePulse <= 1'b0;
      highSideEnable <= 1'b1;
      voltageMode <= 1'b0;
      pulsesPerPacket <= PPP_RESET;
      peakThresholdMv <= THR_RESET;
      thrSource <= SRC_LOOP;
    end else begin
      mode <= next_mode;
      pkt <= next_pkt;
      periodCnt <= next_periodCnt;
      waitCnt <= next_waitCnt;
      pulseCnt <= next_pulseCnt;
      slowCnt <= next_slowCnt;
      zcdPrev <= syncOut[0];
      wakeLine <= next_wakeLine;
      lowSideGatePulse <= next_lowSideGatePulse;
      highSideEnable <= next_highSideEnable;
      voltageMode <= next_voltageMode;
      pulsesPerPacket <= next_pulsesPerPacket;
      peakThresholdMv <= next_peakThresholdMv;
      thrSource <= next_thrSource;
    end
  end

  assign burstMode = mode;

  // ==========================================================
  // Checks
  // Counts cycles the wake line has been high, for the delay check.
  logic [WCNT_W-1:0] wakeAge;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wakeAge <= '0;
    end else if (!wakeLine) begin
      wakeAge <= '0;
    end else if (wakeAge != '1) begin
      wakeAge <= wakeAge + 10'h001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_enter_low; $past(mode) == ST_ADAPTIVE && mode == ST_LOWPOWER; endsequence
  sequence s_enter_first; $past(mode) == ST_LOWPOWER && mode == ST_FIRST_STANDBY; endsequence
  property p_wake_delay;
    lowSideGatePulse |-> wakeLine && wakeAge >= WAKE_LAST + 10'h001; endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("wake delay cut short"); // [R4] [R15]
  property p_valley; lowSideGatePulse |-> $past(zcdEdge) && !highSideEnable; endproperty
  a_valley: assert property (p_valley) else $error("low-side pulse without a valley"); // [R5]
  property p_end;
    $fell(wakeLine) |-> $past(zcdEdge) && $past(pulseCnt) == $past(pulsesPerPacket); endproperty
  a_end: assert property (p_end) else $error("wake dropped before last valley"); // [R6]
  property p_low_entry;
    s_enter_low |-> $past(abmTwoPulses) && $past(slowCnt) == 2'h1 ##1 !highSideEnable; endproperty
  a_low_entry: assert property (p_low_entry) else $error("low-power entry too early"); // [R1]
  property p_low_rate;
    $rose(wakeLine) && mode == ST_LOWPOWER && $past(mode) == ST_LOWPOWER
      |-> $past(periodCnt) >= LOWPWR_CYC - 18'h00001 && pulsesPerPacket == PPP_LOW; endproperty
  a_low_rate: assert property (p_low_rate) else $error("low-power packet timing"); // [R2]
  property p_first_entry; s_enter_first |-> $past(floorS) && !highSideEnable; endproperty
  a_first_entry: assert property (p_first_entry) else $error("entry without floor"); // [R8]
  property p_second_ppp; mode == ST_SECOND_STANDBY |-> pulsesPerPacket == PPP_SECOND; endproperty
  a_second_ppp: assert property (p_second_ppp) else $error("pulse count not doubled"); // [R11]
  property p_prog_clamp;
    thrSource == SRC_PROGRAM |-> mode == ST_SECOND_STANDBY
      && peakThresholdMv >= THR_MIN_MV && peakThresholdMv <= THR_MAX_MV; endproperty
  a_prog_clamp: assert property (p_prog_clamp) else $error("threshold unclamped"); // [R12]
  property p_first_floor;
    mode == ST_FIRST_STANDBY |-> thrSource == SRC_FLOOR && pulsesPerPacket == PPP_LOW; endproperty
  a_first_floor: assert property (p_first_floor) else $error("floor or count wrong"); // [R9]
  property p_vmode; voltageMode |-> mode == ST_LOWPOWER; endproperty
  a_vmode: assert property (p_vmode) else $error("voltage mode outside low power"); // [R7]
endmodule : light_load_burst_mode_sequencer

// [lbm_pkg.sv]
// Purpose: Shared constants and types for the light-load burst sequencer.
// Assumes: 200 MHz core clock.
// Notes: Rates become packet periods in clock cycles.
package lbm_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned WAKE_DELAY_NS = 2200;
  localparam int unsigned WAKE_CYC =
    (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOWPWR_RATE_HZ = 25000;
  localparam int unsigned ENTRY_RATE_HZ = 8500;
  localparam int unsigned RETURN_RATE_HZ = 1700;
  localparam int unsigned LOWPWR_PERIOD_CYC = CLK_HZ / LOWPWR_RATE_HZ;
  localparam int unsigned ENTRY_PERIOD_CYC = CLK_HZ / ENTRY_RATE_HZ;
  localparam int unsigned RETURN_PERIOD_CYC = CLK_HZ / RETURN_RATE_HZ;
  // ==========================================================
  // Widths and values
  localparam int CNT_W = 18;
  localparam int WCNT_W = 10;
  localparam int PPP_W = 4;
  localparam int THR_W = 9;
  localparam logic [WCNT_W-1:0] WAKE_LAST = WCNT_W'(WAKE_CYC - 1);
  localparam logic [PPP_W-1:0] PPP_LOW = 4'h2;
  localparam logic [PPP_W-1:0] PPP_SECOND = 4'(PPP_LOW * 2);
  localparam logic [PPP_W-1:0] PPP_RESET = 4'h0;
  localparam logic [THR_W-1:0] THR_MIN_MV = 9'h10E;
  localparam logic [THR_W-1:0] THR_MAX_MV = 9'h190;
  localparam logic [THR_W-1:0] THR_RESET = 9'h000;
  localparam logic [1:0] SLOW_QUAL = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_ADAPTIVE, ST_LOWPOWER, ST_FIRST_STANDBY, ST_SECOND_STANDBY
  } mode_t;
  typedef enum logic [1:0] {PK_IDLE, PK_WAKE, PK_VALLEY} pkt_t;
  typedef enum logic [1:0] {SRC_LOOP, SRC_FLOOR, SRC_PROGRAM} src_t;
endpackage : lbm_pkg

// [ring_model.sv]
// Purpose: Power stage stand-in that produces auxiliary zero-crossing valleys.
// Assumes: The stage only rings while the wake line holds the driver awake.
// Notes: Valley edges are placed off the clock edge, like a free comparator.
`timescale 1ns/1ps
module ring_model #(
  parameter int GAP = 40
) (
  // Clock and wake
  input wire logic core_clk,
  input wire logic wakeLine,
  // Comparator output
  output logic auxZeroCrossing
);
  // ==========================================================
  // Valley train
  // Valleys keep coming during the wake delay, so the design has to refuse them.
  initial begin
    auxZeroCrossing = 1'b0;
    forever begin
      @(posedge core_clk);
      // Look after the edge, once the registered wake line has settled.
      #1;
      if (wakeLine) begin
        repeat (GAP) @(posedge core_clk);
        #2 auxZeroCrossing = 1'b1;
        repeat (4) @(posedge core_clk);
        #3 auxZeroCrossing = 1'b0;
      end
    end
  end
endmodule : ring_model

// [light_load_burst_mode_sequencer_tb.sv]
// Purpose: Self-checking bench for the light-load burst sequencer.
// Assumes: Rate periods scaled down by ten to keep the run short.
// Notes: Packets are measured from the wake line and the low-side pulses.
`timescale 1ns/1ps
module light_load_burst_mode_sequencer_tb;
  import lbm_pkg::*;
  localparam logic [CNT_W-1:0] LP = 18'h00320;
  localparam logic [CNT_W-1:0] EN = 18'h00931;
  localparam logic [CNT_W-1:0] RT = 18'h02DF5;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic abmTwoPulses = 1'b0;
  logic abmPacketStart = 1'b0;
  logic packetDemand = 1'b0;
  logic optionStrapRef = 1'b0;
  logic thresholdFloor = 1'b0;
  logic peakProgramPinHigh = 1'b0;
  logic [THR_W-1:0] loopThresholdMv = 9'h140;
  logic [THR_W-1:0] programThresholdMv = 9'h000;
  logic auxZeroCrossing, wakeLine, lowSideGatePulse, highSideEnable, voltageMode;
  mode_t burstMode;
  logic [PPP_W-1:0] pulsesPerPacket;
  logic [THR_W-1:0] peakThresholdMv;
  src_t thrSource;
  logic [THR_W-1:0] pv[3] = '{9'h1F4, 9'h12C, 9'h064};
  logic [THR_W-1:0] ev[3] = '{9'h190, 9'h12C, 9'h10E};
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int rise = 0;
  int d, p, t0, t;
  // ==========================================================
  // Clock and parts
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  light_load_burst_mode_sequencer #(.LOWPWR_CYC(LP), .ENTRY_CYC(EN), .RETURN_CYC(RT),
    .FLOOR_MV(THR_MIN_MV)) uut (.core_clk(core_clk), .nrst(nrst),
    .abmTwoPulses(abmTwoPulses), .abmPacketStart(abmPacketStart),
    .packetDemand(packetDemand), .optionStrapRef(optionStrapRef),
    .auxZeroCrossing(auxZeroCrossing), .thresholdFloor(thresholdFloor),
    .peakProgramPinHigh(peakProgramPinHigh), .loopThresholdMv(loopThresholdMv),
    .programThresholdMv(programThresholdMv), .wakeLine(wakeLine),
    .lowSideGatePulse(lowSideGatePulse), .highSideEnable(highSideEnable),
    .voltageMode(voltageMode), .burstMode(burstMode), .pulsesPerPacket(pulsesPerPacket),
    .peakThresholdMv(peakThresholdMv), .thrSource(thrSource));
  ring_model #(.GAP(40)) stage (.core_clk(core_clk), .wakeLine(wakeLine),
    .auxZeroCrossing(auxZeroCrossing));
  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic bail();
    miscompares++;
    complete_run();
  endtask : bail
  task automatic pulse_in(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse_in
  // Waits for one packet, then reports wake-to-first-pulse delay and pulse count.
  task automatic packet();
    int n;
    n = 0;
    while (wakeLine !== 1'b1) begin
      n++;
      if (n > 20000) bail();
      tick(1);
    end
    rise = cyc;
    d = -1;
    p = 0;
    n = 0;
    while (wakeLine === 1'b1) begin
      if (lowSideGatePulse === 1'b1) begin
        if (p == 0) d = n;
        p++;
      end
      n++;
      if (n > 5000) bail();
      tick(1);
    end
  endtask : packet
  task automatic demand_pkt(input int spacing);
    t0 = cyc;
    pulse_in(packetDemand);
    packet();
    tick(spacing - (cyc - t0));
  endtask : demand_pkt
  // ==========================================================
  // Sequence
  initial begin
    #1;
    tick(2);
    chk("mode", burstMode, ST_ADAPTIVE);
    chk("wake", wakeLine, 1'b0);
    chk("hsen", highSideEnable, 1'b1);
    nrst = 1'b1;
    tick(3);
    optionStrapRef = 1'b1;
    tick(4);
    chk("vmode", voltageMode, 1'b0);
    abmTwoPulses = 1'b1;
    // A fast period between slow ones must restart the qualification.
    pulse_in(abmPacketStart);
    tick(900);
    pulse_in(abmPacketStart);
    tick(100);
    pulse_in(abmPacketStart);
    tick(900);
    pulse_in(abmPacketStart);
    tick(900);
    chk("mode", burstMode, ST_ADAPTIVE);
    chk("hsen", highSideEnable, 1'b1);
    pulse_in(abmPacketStart);
    tick(2);
    chk("mode", burstMode, ST_LOWPOWER);
    chk("hsen", highSideEnable, 1'b0);
    packet();
    t = rise;
    chk("pulses", p, 2);
    chk("delay", d >= int'(WAKE_CYC), 1);
    packet();
    chk("spacing", rise - t, LP);
    chk("ppp", pulsesPerPacket, PPP_LOW);
    chk("vmode", voltageMode, 1'b1);
    chk("src", thrSource, SRC_LOOP);
    loopThresholdMv = 9'h150;
    tick(4);
    chk("thr", peakThresholdMv, 9'h150);
    optionStrapRef = 1'b0;
    tick(4);
    chk("vmode", voltageMode, 1'b0);
    thresholdFloor = 1'b1;
    tick(6);
    chk("mode", burstMode, ST_FIRST_STANDBY);
    chk("hsen", highSideEnable, 1'b0);
    chk("ppp", pulsesPerPacket, PPP_LOW);
    chk("thr", peakThresholdMv, THR_MIN_MV);
    chk("src", thrSource, SRC_FLOOR);
    demand_pkt(2500);
    chk("pulses", p, 2);
    chk("delay", d >= int'(WAKE_CYC), 1);
    chk("mode", burstMode, ST_FIRST_STANDBY);
    demand_pkt(5000);
    chk("mode", burstMode, ST_SECOND_STANDBY);
    chk("thr", peakThresholdMv, THR_MIN_MV);
    demand_pkt(2000);
    chk("mode", burstMode, ST_SECOND_STANDBY);
    chk("pulses", p, 4);
    chk("ppp", pulsesPerPacket, PPP_SECOND);
    demand_pkt(2500);
    chk("mode", burstMode, ST_FIRST_STANDBY);
    demand_pkt(5000);
    chk("mode", burstMode, ST_SECOND_STANDBY);
    peakProgramPinHigh = 1'b1;
    for (int i = 0; i < 3; i++) begin
      programThresholdMv = pv[i];
      tick(6);
      chk("thr", peakThresholdMv, ev[i]);
      chk("src", thrSource, SRC_PROGRAM);
    end
    demand_pkt(100);
    chk("mode", burstMode, ST_FIRST_STANDBY);
    complete_run();
  end
endmodule : light_load_burst_mode_sequencer_tb
